// ### pkg/itimer_map.vh
// register offsets, control word fields and codes for the interval timer port
`ifndef ITIMER_MAP_VH
`define ITIMER_MAP_VH
`define ITM_PORT_CH0 2'h0
`define ITM_PORT_CH1 2'h1
`define ITM_PORT_CH2 2'h2
`define ITM_PORT_CTRL 2'h3
`define ITM_CW_SEL_HI 7
`define ITM_CW_SEL_LO 6
`define ITM_CW_ACC_HI 5
`define ITM_CW_ACC_LO 4
`define ITM_CW_MODE_HI 3
`define ITM_CW_MODE_MID 2
`define ITM_CW_MODE_LO 1
`define ITM_CW_BCD 0
`define ITM_SEL_ILLEGAL 2'h3
`define ITM_ACC_LATCH 2'h0
`define ITM_ACC_LOW 2'h1
`define ITM_ACC_HIGH 2'h2
`define ITM_ACC_BOTH 2'h3
`define ITM_MODE_RST 3'h0
`define ITM_ACC_RST 2'h3
`define ITM_COUNT_RST 16'h0000
`endif

// ### rtl/itm_channel.v
// one timer channel: programming state, count loading, down counting and readback
`timescale 1ns/100ps
module itm_channel #(
  parameter W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire cw_wr,
  input wire [7:0] cw,
  input wire cnt_wr,
  input wire cnt_rd,
  input wire [7:0] wdata,
  input wire cnt_clk,
  input wire gate,
  output reg [7:0] rdata_q,
  output wire [2:0] mode,
  output wire bcd,
  output wire [1:0] access,
  output wire [W-1:0] count,
  output wire loaded
);
`include "itimer_map.vh"
  reg [2:0] mode_q;
  reg bcd_q;
  reg [1:0] acc_q;
  reg [W-1:0] hold_q;
  reg [W-1:0] cnt_q;
  reg [W-1:0] latch_q;
  reg latched_q;
  reg wptr_q;
  reg rptr_q;
  reg pend_q;
  reg armed_q;
  reg run_q;
  reg clk_prev_q;
  reg rose_q;
  wire is_latch;
  wire rise;
  wire fall;
  wire [W-1:0] dec;
  wire [W-1:0] src;
  wire last_w;
  wire last_r;
  assign is_latch = (cw[`ITM_CW_ACC_HI:`ITM_CW_ACC_LO] == `ITM_ACC_LATCH);
  assign rise = cnt_clk & ~clk_prev_q;
  assign fall = ~cnt_clk & clk_prev_q;
  assign last_w = (acc_q != `ITM_ACC_BOTH) | wptr_q;
  assign last_r = (acc_q != `ITM_ACC_BOTH) | rptr_q;
  assign src = latched_q ? latch_q : cnt_q;
  // bcd decrement per decade; zero wraps to 9999, giving the full 10^4 count
  function [W-1:0] bcd_dec;
    input [W-1:0] v;
    integer i;
    reg borrow;
    begin
      bcd_dec = v;
      borrow = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        if (borrow) begin
          if (v[i*4 +: 4] == 4'h0) begin
            bcd_dec[i*4 +: 4] = 4'h9;
          end else begin
            bcd_dec[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
  endfunction
  // binary zero wraps to ffff, so a zero load spans 2^16 counts
  assign dec = bcd_q ? bcd_dec(cnt_q) : cnt_q - {{(W-1){1'b0}}, 1'b1};
  always @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= `ITM_MODE_RST;
      bcd_q <= 1'b0;
      acc_q <= `ITM_ACC_RST;
      hold_q <= `ITM_COUNT_RST;
      cnt_q <= `ITM_COUNT_RST;
      latch_q <= `ITM_COUNT_RST;
      latched_q <= 1'b0;
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      pend_q <= 1'b0;
      armed_q <= 1'b0;
      run_q <= 1'b0;
      clk_prev_q <= 1'b0;
      rose_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      clk_prev_q <= cnt_clk;
      if (cw_wr && is_latch) begin
        // snapshot only; mode, format and access stay as programmed
        if (!latched_q) begin
          latch_q <= cnt_q;
          latched_q <= 1'b1;
        end
      end else if (cw_wr) begin
        // x1x codes drop the top bit, so codes 6 and 7 read back as 2 and 3
        mode_q <= cw[`ITM_CW_MODE_MID] ? {1'b0, cw[`ITM_CW_MODE_MID:`ITM_CW_MODE_LO]} :
          cw[`ITM_CW_MODE_HI:`ITM_CW_MODE_LO];
        bcd_q <= cw[`ITM_CW_BCD];
        acc_q <= cw[`ITM_CW_ACC_HI:`ITM_CW_ACC_LO];
        wptr_q <= 1'b0;
        rptr_q <= 1'b0;
        latched_q <= 1'b0;
        pend_q <= 1'b0;
        run_q <= 1'b0;
      end else if (cnt_wr) begin
        case (acc_q)
          `ITM_ACC_LOW: hold_q <= {8'h00, wdata};
          `ITM_ACC_HIGH: hold_q <= {wdata, 8'h00};
          default: begin
            if (wptr_q) begin
              hold_q[15:8] <= wdata;
            end else begin
              hold_q[7:0] <= wdata;
            end
          end
        endcase
        if (acc_q == `ITM_ACC_BOTH) begin
          wptr_q <= ~wptr_q;
        end
        // first byte of a two-byte load halts a mode 0 count until the load completes
        if (mode_q == 3'h0 && !last_w) begin
          run_q <= 1'b0;
        end
        pend_q <= last_w;
        rose_q <= 1'b0;
        armed_q <= 1'b0;
      end else if (cnt_rd) begin
        case (acc_q)
          `ITM_ACC_LOW: rdata_q <= src[7:0];
          `ITM_ACC_HIGH: rdata_q <= src[15:8];
          default: rdata_q <= rptr_q ? src[15:8] : src[7:0];
        endcase
        if (acc_q == `ITM_ACC_BOTH) begin
          rptr_q <= ~rptr_q;
        end
        if (last_r) begin
          latched_q <= 1'b0;
        end
      end
      // load transfers on the channel clock's falling edge after a rising edge
      if (pend_q && !cnt_wr && !cw_wr) begin
        if (rise) begin
          rose_q <= 1'b1;
        end
        if (fall && rose_q) begin
          cnt_q <= hold_q;
          pend_q <= 1'b0;
          rose_q <= 1'b0;
          run_q <= 1'b1;
          armed_q <= 1'b1;
        end
      end
      // counting runs on falling edges while gated on; a control word strobe to this channel skips that edge
      if (run_q && !(pend_q && rose_q && fall) && fall && gate && !cw_wr) begin
        cnt_q <= dec;
      end
    end
  end
  assign mode = mode_q;
  assign bcd = bcd_q;
  assign access = acc_q;
  assign count = cnt_q;
  assign loaded = armed_q;
endmodule // itm_channel

// ### rtl/itm_host_port.v
// three-channel interval timer host port: decode, control word dispatch, read mux
`timescale 1ns/100ps
module itm_host_port #(
  parameter NCH = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire port_pick_lo,
  input wire port_pick_hi,
  input wire [7:0] data_in,
  output reg [7:0] data_out_q,
  output reg data_oe_n_q,
  input wire [NCH-1:0] cnt_clk,
  input wire [NCH-1:0] gate,
  output wire [3*NCH-1:0] ch_mode,
  output wire [NCH-1:0] ch_bcd,
  output wire [2*NCH-1:0] ch_access,
  output wire [16*NCH-1:0] ch_count,
  output wire [NCH-1:0] ch_loaded
);
`include "itimer_map.vh"
  wire [1:0] port;
  wire wr_act;
  wire rd_act;
  wire [1:0] cw_sel;
  reg wr_prev_q;
  reg rd_prev_q;
  wire wr_stb;
  wire rd_stb;
  wire [8*NCH-1:0] ch_rdata;
  wire [7:0] sel_rdata;
  assign port = {port_pick_hi, port_pick_lo};
  assign wr_act = ~cs_n & ~wr_n & rd_n;
  assign rd_act = ~cs_n & ~rd_n & wr_n;
  // act once per strobe so a multi-cycle strobe moves a byte pointer only once
  assign wr_stb = wr_act & ~wr_prev_q;
  assign rd_stb = rd_act & ~rd_prev_q;
  assign cw_sel = data_in[`ITM_CW_SEL_HI:`ITM_CW_SEL_LO];
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_act;
      rd_prev_q <= rd_act;
    end
  end
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // each channel owns its own state, so order of programming is free
      itm_channel #(.W(16)) u_ch (
        .clk(clk),
        .sys_rst(sys_rst),
        .cw_wr(wr_stb && port == `ITM_PORT_CTRL && cw_sel == g),
        .cw(data_in),
        .cnt_wr(wr_stb && port == g),
        .cnt_rd(rd_stb && port == g),
        .wdata(data_in),
        .cnt_clk(cnt_clk[g]),
        .gate(gate[g]),
        .rdata_q(ch_rdata[8*g +: 8]),
        .mode(ch_mode[3*g +: 3]),
        .bcd(ch_bcd[g]),
        .access(ch_access[2*g +: 2]),
        .count(ch_count[16*g +: 16]),
        .loaded(ch_loaded[g])
      );
    end
  endgenerate
  assign sel_rdata = ch_rdata[8*port +: 8];
  // channel registers its byte on the strobe edge; drive it out a cycle later
  always @(posedge clk) begin
    if (sys_rst) begin
      data_out_q <= 8'h00;
      data_oe_n_q <= 1'b1;
    end else begin
      data_oe_n_q <= ~(rd_act && rd_prev_q && port != `ITM_PORT_CTRL);
      data_out_q <= (port == `ITM_PORT_CTRL) ? 8'h00 : sel_rdata;
    end
  end
endmodule // itm_host_port

// ### tb/itm_host_model.sv
// host processor model driving the timer bus pins
`timescale 1ns/100ps
module itm_host_model (
  input wire clk,
  output reg cs_n,
  output reg rd_n,
  output reg wr_n,
  output reg [1:0] port,
  output reg [7:0] data,
  input wire [7:0] rdata,
  input wire oe_n
);
  initial {cs_n, rd_n, wr_n, port, data} = 13'h1c00;
  // strobes high two full cycles between accesses; idle data inverted, not held
  task wr(input [1:0] p, input [7:0] d, input s);
    begin
      @(negedge clk) {cs_n, wr_n, port, data} = {s, 1'b0, p, d};
      repeat (2) @(negedge clk);
      {cs_n, wr_n, data} = {2'h3, ~d};
      @(negedge clk);
    end
  endtask
  // whole read sequence always finished before anything else
  task rd(input [1:0] p, output [7:0] d, output o);
    begin
      @(negedge clk) {cs_n, rd_n, port} = {2'h0, p};
      repeat (4) @(negedge clk);
      {d, o} = {rdata, oe_n};
      {cs_n, rd_n} = 2'h3;
      @(negedge clk);
    end
  endtask
endmodule // itm_host_model

// ### tb/itm_host_port_monitor.sv
// assertion checker bound to the interval timer host port
`timescale 1ns/100ps
module itm_monitor #(parameter NCH = 3) (
  input wire clk,
  input wire sys_rst,
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire port_pick_lo,
  input wire port_pick_hi,
  input wire [7:0] data_in,
  input wire data_oe_n_q,
  input wire [NCH-1:0] cnt_clk,
  input wire [3*NCH-1:0] ch_mode,
  input wire [2*NCH-1:0] ch_access,
  input wire [16*NCH-1:0] ch_count,
  input wire [NCH-1:0] ch_loaded
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg wr_n_q;
  always @(posedge clk) wr_n_q <= wr_n;
  // strobe edge only, so a long write is seen once
  wire cw_w = wr_n_q && !wr_n && !cs_n && rd_n && port_pick_hi && port_pick_lo;
  wire [1:0] sel = data_in[7:6];
  wire rd_ok = !cs_n && !rd_n && wr_n && !(port_pick_hi && port_pick_lo);
  property p_cw;
    cw_w && sel != 2'h3 && data_in[5:4] != 2'h0 |-> ##2
      ch_access[2*$past(sel,2) +: 2] == $past(data_in[5:4],2) &&
      ch_mode[3*$past(sel,2) +: 2] == $past(data_in[2:1],2);
  endproperty
  a_cw: assert property (p_cw) else $error("control word not applied");
  property p_latch;
    cw_w && data_in[5:4] == 2'h0 |-> ##2
      ch_access == $past(ch_access,2) && ch_mode == $past(ch_mode,2);
  endproperty
  a_latch: assert property (p_latch) else $error("latch changed setup");
  property p_bad;
    cw_w && sel == 2'h3 |-> ##2 ch_access == $past(ch_access,2) && ch_mode == $past(ch_mode,2);
  endproperty
  a_bad: assert property (p_bad) else $error("bad select obeyed");
  property p_rd;
    $fell(rd_n) && rd_ok ##1 rd_ok[*3] |-> !data_oe_n_q;
  endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_ctl;
    (!rd_n && port_pick_hi && port_pick_lo)[*3] |-> data_oe_n_q;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control port drove bus");
  property p_cs;
    cs_n[*3] |-> data_oe_n_q;
  endproperty
  a_cs: assert property (p_cs) else $error("drove while deselected");
  property p_load;
    $stable(cnt_clk)[*5] |-> (ch_loaded & ~$past(ch_loaded)) == 0;
  endproperty
  a_load: assert property (p_load) else $error("load without clock fall");
  property p_hold;
    ch_mode[2:0] == 3'h0 && ch_access[1:0] == 2'h3 && !ch_loaded[0] && !$past(ch_loaded[0]) |->
      $stable(ch_count[15:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("mode 0 counted early");
endmodule // itm_monitor
bind itm_host_port itm_monitor #(.NCH(NCH)) u_mon (.*);

// ### tb/testbench.sv
// self-checking bench for the interval timer host port
`timescale 1ns/100ps
module testbench;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [2:0] cnt_clk = 3'h0;
  reg [2:0] gate = 3'h0;
  wire cs_n, rd_n, wr_n, oe_n;
  wire [1:0] port;
  wire [7:0] din, dout;
  wire [8:0] mo;
  wire [2:0] bc, ld;
  wire [5:0] ac;
  wire [47:0] cnt;
  reg [7:0] rb;
  reg ro;
  integer fail_count = 0;
  integer checked = 0;
  always #50 clk = ~clk;
  itm_host_model h (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .port(port),
    .data(din), .rdata(dout), .oe_n(oe_n));
  itm_host_port dut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_pick_lo(port[0]), .port_pick_hi(port[1]), .data_in(din), .data_out_q(dout),
    .data_oe_n_q(oe_n), .cnt_clk(cnt_clk), .gate(gate), .ch_mode(mo), .ch_bcd(bc),
    .ch_access(ac), .ch_count(cnt), .ch_loaded(ld));
  task chk(input [63:0] got, input [63:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one rise then one fall on every counting clock
  task pulse;
    begin
      repeat (2) @(negedge clk) cnt_clk = ~cnt_clk;
      repeat (3) @(negedge clk);
    end
  endtask
  task rchk(input [1:0] p, input [7:0] e);
    begin
      h.rd(p, rb, ro);
      chk({ro, rb}, {1'b0, e});
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  // run needs about 175 cycles; a hang is cut well past that
  initial begin
    #200000 fail_count = fail_count + 1;
    stop_test;
  end
  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    chk({ac, ld, oe_n, mo, bc}, {6'h3f, 3'h0, 1'b1, 12'h0});
    h.wr(2'h3, 8'h1e, 1'b0);
    h.wr(2'h3, 8'h7d, 1'b0);
    h.wr(2'h3, 8'ha4, 1'b0);
    chk({mo, bc, ac}, {9'o223, 3'b010, 6'h2d});
    h.wr(2'h1, 8'h34, 1'b0);
    h.wr(2'h0, 8'h05, 1'b0);
    h.wr(2'h1, 8'h12, 1'b0);
    h.wr(2'h2, 8'h00, 1'b0);
    chk(ld, 3'h0);
    pulse;
    chk({ld, cnt}, {3'h7, 32'h1234, 16'h0005});
    rchk(2'h1, 8'h34);
    rchk(2'h1, 8'h12);
    rchk(2'h0, 8'h05);
    rchk(2'h2, 8'h00);
    gate = 3'h6;
    h.wr(2'h1, 8'h00, 1'b0);
    h.wr(2'h1, 8'h00, 1'b0);
    pulse;
    pulse;
    chk(cnt, {32'hfffe9999, 16'h0005});
    h.wr(2'h3, 8'h4f, 1'b0);
    pulse;
    rchk(2'h1, 8'h99);
    rchk(2'h1, 8'h99);
    chk({mo, ac, cnt[31:16]}, {9'o223, 6'h2d, 16'h9998});
    h.wr(2'h3, 8'hf0, 1'b0);
    h.wr(2'h3, 8'h30, 1'b1);
    chk({mo, ac}, {9'o223, 6'h2d});
    h.rd(2'h3, rb, ro);
    chk(ro, 1'b1);
    h.wr(2'h3, 8'h30, 1'b0);
    h.wr(2'h0, 8'h10, 1'b0);
    gate = 3'h7;
    pulse;
    chk({ld[0], cnt[15:0]}, {1'b0, 16'h0005});
    h.wr(2'h0, 8'h00, 1'b0);
    pulse;
    chk(cnt[15:0], 16'h0010);
    pulse;
    chk(cnt[15:0], 16'h000f);
    h.wr(2'h0, 8'h20, 1'b0);
    pulse;
    chk({ld[0], cnt[15:0]}, {1'b0, 16'h000f});
    h.wr(2'h0, 8'h00, 1'b0);
    pulse;
    chk({ld[0], cnt[15:0]}, {1'b1, 16'h0020});
    stop_test;
  end
endmodule // testbench
